// [tb/lers_bus_model.sv]
// processor side bus master model driving the synchroniser's write and read strobes
`timescale 1ns/10ps

module lers_bus_model (
	input  wire logic        sys_clk,
	input  wire logic [3:0]  sync_pending_flags,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_valid,
	output logic             wr_en,
	output logic [1:0]       wr_idx,
	output logic [31:0]      wr_data,
	output logic             rd_en,
	output logic [1:0]       rd_idx
);
	initial
	begin
		wr_en = 1'h0;
		wr_idx = 2'h0;
		wr_data = 32'h0;
		rd_en = 1'h0;
		rd_idx = 2'h0;
	end

	// waits up to 300 cycles for a busy register to clear; ends just after the edge that takes the write
	task automatic write_reg(input logic [1:0] i, input logic [31:0] d);
		for (int k = 0; k < 300 && sync_pending_flags[i] !== 1'h0; k++)
		begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		wr_en <= 1'h1;
		wr_idx <= i;
		wr_data <= d;
		@(posedge sys_clk);
		wr_en <= 1'h0;
		#1;
	endtask

	// v[1] is rd_valid just after the taking edge, v[0] one cycle later
	task automatic read_reg(input logic [1:0] i, output logic [31:0] d, output logic [1:0] v);
		@(posedge sys_clk);
		rd_en <= 1'h1;
		rd_idx <= i;
		@(posedge sys_clk);
		rd_en <= 1'h0;
		#1;
		d = rd_data;
		v[1] = rd_valid;
		@(posedge sys_clk);
		#1;
		v[0] = rd_valid;
	endtask
endmodule

// [tb/lers_sync_tb.sv]
// self-checking bench for the low energy register synchroniser
`timescale 1ns/10ps

module lers_sync_tb;
	logic         sys_clk, rstn, lf_clk_in, deep_sleep_state, update_hold_bit;
	logic         wr_en, rd_en, rd_valid, lf_q, lf_q2;
	logic [1:0]   wr_idx, rd_idx, v;
	logic [2:0]   lf_div;
	logic [31:0]  wr_data, rd_data, d;
	logic [3:0]   sync_pending_flags;
	logic [127:0] periph_value_in, lf_reg_values;
	int           err_count, samples_checked, n;

	lers_sync lers_sync_i (.sys_clk(sys_clk), .rstn(rstn), .lf_clk_in(lf_clk_in),
		.deep_sleep_state(deep_sleep_state), .update_hold_bit(update_hold_bit), .wr_en(wr_en),
		.wr_idx(wr_idx), .wr_data(wr_data), .rd_en(rd_en), .rd_idx(rd_idx),
		.periph_value_in(periph_value_in), .rd_data(rd_data), .rd_valid(rd_valid),
		.sync_pending_flags(sync_pending_flags), .lf_reg_values(lf_reg_values));

	lers_bus_model lers_bus_model_i (.sys_clk(sys_clk), .sync_pending_flags(sync_pending_flags),
		.rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en), .wr_idx(wr_idx),
		.wr_data(wr_data), .rd_en(rd_en), .rd_idx(rd_idx));

	initial
	begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	// slow clock of ten core cycles, made on core edges so sampling never races
	always @(posedge sys_clk)
	begin
		lf_div <= (lf_div == 3'h4) ? 3'h0 : lf_div + 3'h1;
		lf_clk_in <= (lf_div == 3'h4) ? ~lf_clk_in : lf_clk_in;
		lf_q <= lf_clk_in;
		lf_q2 <= lf_q;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// waits for all flags to drop, counting rising slow clock edges seen meanwhile
	task automatic wait_idle();
		n = 0;
		for (int k = 0; k < 300 && sync_pending_flags !== 4'h0; k++)
		begin
			@(posedge sys_clk);
			#1;
			if (lf_q && !lf_q2)
				n++;
		end
		chk({28'h0, sync_pending_flags}, 32'h0);
	endtask

	task automatic t_land();
		lers_bus_model_i.write_reg(2'h0, 32'h1234abcd);
		chk({28'h0, sync_pending_flags}, 32'h1);
		chk(lf_reg_values[31:0], 32'h0);
		wait_idle();
		chk(n, 32'h3);
		chk(lf_reg_values[31:0], 32'h1234abcd);
	endtask

	task automatic t_hold();
		@(posedge sys_clk);
		update_hold_bit <= 1'h1;
		lers_bus_model_i.write_reg(2'h1, 32'h0000aaaa);
		lers_bus_model_i.write_reg(2'h2, 32'h0000bbbb);
		repeat (40) @(posedge sys_clk);
		#1;
		chk({28'h0, sync_pending_flags}, 32'h6);
		chk(lf_reg_values[63:32], 32'h0);
		chk(lf_reg_values[95:64], 32'h0);
		@(posedge sys_clk);
		update_hold_bit <= 1'h0;
		for (int k = 0; k < 300 && sync_pending_flags === 4'h6; k++)
		begin
			@(posedge sys_clk);
			#1;
		end
		chk({28'h0, sync_pending_flags}, 32'h0);
		chk(lf_reg_values[63:32], 32'h0000aaaa);
		chk(lf_reg_values[95:64], 32'h0000bbbb);
	endtask

	task automatic t_sleep();
		lers_bus_model_i.write_reg(2'h0, 32'hc0de0001);
		@(posedge sys_clk);
		deep_sleep_state <= 1'h1;
		lers_bus_model_i.read_reg(2'h0, d, v);
		chk(v, 2'h0);
		lers_bus_model_i.write_reg(2'h1, 32'h0d0d0d0d);
		chk({31'h0, sync_pending_flags[1]}, 32'h0);
		wait_idle();
		chk(lf_reg_values[31:0], 32'hc0de0001);
		chk(lf_reg_values[63:32], 32'h0000aaaa);
		@(posedge sys_clk);
		deep_sleep_state <= 1'h0;
	endtask

	task automatic t_read();
		@(posedge sys_clk);
		periph_value_in[127:96] <= 32'h9e9e0077;
		lers_bus_model_i.write_reg(2'h3, 32'h55aa55aa);
		lers_bus_model_i.write_reg(2'h0, 32'h0badf00d);
		lers_bus_model_i.read_reg(2'h0, d, v);
		chk(d, 32'h0badf00d);
		chk(v, 2'h2);
		chk({31'h0, sync_pending_flags[0]}, 32'h1);
		wait_idle();
		chk(lf_reg_values[127:96], 32'h55aa55aa);
		lers_bus_model_i.read_reg(2'h3, d, v);
		chk(d, 32'h9e9e0077);
		chk(v, 2'h2);
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#50000;
		err_count++;
		tally_and_finish();
	end

	initial
	begin
		rstn = 1'h0;
		lf_clk_in = 1'h0;
		lf_div = 3'h0;
		deep_sleep_state = 1'h0;
		update_hold_bit = 1'h0;
		periph_value_in = 128'h0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'h1;
		t_land();
		t_hold();
		t_sleep();
		t_read();
		tally_and_finish();
	end
endmodule

// [verilog/lers_chan.sv]
// one synchronised register: core copy, pending flag, edge counter, peripheral copy
`timescale 1ns/10ps

module lers_chan #(
	parameter int unsigned DW = 32
) (
	input  wire logic          sys_clk,
	input  wire logic          rstn,
	input  wire logic          wr_stb,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic          lf_edge,
	input  wire logic          hold,
	output logic               pending,
	output logic [DW-1:0]      core_val,
	output logic [DW-1:0]      lf_val
);

	typedef struct packed {
		lers_pkg::lers_chan_st_t        st;
		logic [lers_pkg::CNT_W-1:0]     cnt;
		logic [DW-1:0]                  core;
		logic [DW-1:0]                  lf;
	} lers_chan_state_t;

	lers_chan_state_t state_ff;
	lers_chan_state_t nxt_state;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff.st)
			lers_pkg::LERS_IDLE:
			begin
				nxt_state.cnt = lers_pkg::CNT_RESET;
			end
			lers_pkg::LERS_PEND:
			begin
				// hold freezes the count; written values stay pending [R9] [R10]
				if (!hold && lf_edge)
				begin
					if (state_ff.cnt == lers_pkg::EDGES_TO_LAND - 2'h1)
					begin
						// third peripheral edge: value lands, flag clears [R2] [R3] [R1]
						nxt_state.lf  = state_ff.core;
						nxt_state.st  = lers_pkg::LERS_IDLE;
						nxt_state.cnt = lers_pkg::CNT_RESET;
					end
					else
					begin
						// counting resumes once hold is released [R11]
						nxt_state.cnt = state_ff.cnt + 2'h1;
					end
				end
			end
			default:
			begin
				nxt_state.st = lers_pkg::LERS_IDLE;
			end
		endcase
		// a write in the same cycle as a landing keeps the flag set and restarts the count; the old core value still lands [R3]
		if (wr_stb)
		begin
			nxt_state.core = wr_data;
			nxt_state.st   = lers_pkg::LERS_PEND;
			nxt_state.cnt  = lers_pkg::CNT_RESET;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_ff.st   <= lers_pkg::LERS_IDLE;
			state_ff.cnt  <= lers_pkg::CNT_RESET;
			state_ff.core <= DW'(lers_pkg::WORD_RESET);
			state_ff.lf   <= DW'(lers_pkg::WORD_RESET);
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign pending  = (state_ff.st == lers_pkg::LERS_PEND);
	assign core_val = state_ff.core;
	assign lf_val   = state_ff.lf;

	////////////////////////////////////////////////////////////////////////////
	a_write_sets_busy: assert property (@(posedge sys_clk) disable iff (!rstn) // [R3]
		wr_stb |=> pending && core_val == $past(wr_data))
		else $error("busy flag or core copy not set by write");

	a_land_on_third: assert property (@(posedge sys_clk) disable iff (!rstn) // [R2]
		pending && !wr_stb && !hold && lf_edge && state_ff.cnt == lers_pkg::EDGES_TO_LAND - 2'h1
		|=> !pending && lf_val == $past(core_val))
		else $error("write did not land on third peripheral edge");

	a_no_early_land: assert property (@(posedge sys_clk) disable iff (!rstn) // [R2]
		$fell(pending) |-> $past(state_ff.cnt) == 2'h2 && $past(lf_edge) && !$past(hold))
		else $error("write landed before third peripheral edge");

	a_lf_copy_source: assert property (@(posedge sys_clk) disable iff (!rstn) // [R1]
		(lf_val != $past(lf_val)) |-> $past(pending) && $past(state_ff.cnt) == 2'h2 && lf_val == $past(core_val))
		else $error("peripheral copy changed outside a landing");

	a_hold_keeps_pending: assert property (@(posedge sys_clk) disable iff (!rstn) // [R9]
		pending && hold |=> pending && $stable(lf_val))
		else $error("transfer progressed while hold was set");

	a_release_counts: assert property (@(posedge sys_clk) disable iff (!rstn) // [R11]
		pending && !hold && !wr_stb && lf_edge && state_ff.cnt < 2'h2
		|=> state_ff.cnt == $past(state_ff.cnt) + 2'h1)
		else $error("count did not advance after hold release");

endmodule

// [verilog/lers_pkg.sv]
// shared constants for the low energy register synchroniser
package lers_pkg;

	// width of the per-register edge counter
	localparam int unsigned       CNT_W         = 2;
	// rising edges of the peripheral clock needed before a write lands
	localparam logic [CNT_W-1:0]  EDGES_TO_LAND = 2'h3;
	// counter value after reset and after each landed write
	localparam logic [CNT_W-1:0]  CNT_RESET     = 2'h0;
	// value of every register copy after reset
	localparam logic [31:0]       WORD_RESET    = 32'h0;

	typedef enum logic {
		LERS_IDLE,
		LERS_PEND
	} lers_chan_st_t;

endpackage

// [verilog/lers_sync.sv]
// low energy register synchroniser: core writes into the peripheral clock domain, reads back
`timescale 1ns/10ps

// Contract
// [R1] each written register value is delivered consistently into the peripheral domain
// [R2] a write lands only after three rising edges of the peripheral clock
// [R3] a write sets that register's busy flag until its transfer completes
// [R4] software must not rewrite a register while its busy flag is set
// [R5] pending transfers finish even when the core enters deep sleep right away
// [R6] peripheral-maintained registers read back peripheral values synchronised into core domain
// [R7] core-domain registers read back directly from the core copy
// [R8] software judges write completion by the busy flag, not readback
// [R9] while hold is set, transfers stop and written values stay pending
// [R10] several registers may be written under hold and land together later
// [R11] clearing hold starts transfer of all values written during hold
// [R12] busy flags are read-only and reflect only their own register's transfer

module lers_sync #(
	parameter int unsigned            NUM_REGS     = 4,
	parameter int unsigned            DW           = 32,
	// set bits mark registers whose read value comes from the peripheral
	parameter logic [NUM_REGS-1:0]    PERIPH_OWNED = 4'h8
) (
	input  wire logic                         sys_clk,
	input  wire logic                         rstn,
	input  wire logic                         lf_clk_in,
	input  wire logic                         deep_sleep_state,
	input  wire logic                         update_hold_bit,
	input  wire logic                         wr_en,
	input  wire logic [$clog2(NUM_REGS)-1:0]  wr_idx,
	input  wire logic [DW-1:0]                wr_data,
	input  wire logic                         rd_en,
	input  wire logic [$clog2(NUM_REGS)-1:0]  rd_idx,
	input  wire logic [NUM_REGS*DW-1:0]       periph_value_in,
	output logic [DW-1:0]                     rd_data,
	output logic                              rd_valid,
	output logic [NUM_REGS-1:0]               sync_pending_flags,
	output logic [NUM_REGS*DW-1:0]            lf_reg_values
);

	localparam int unsigned IDX_W = $clog2(NUM_REGS);

	typedef struct packed {
		logic                        lf_prev;
		logic                        rd_valid;
		logic [DW-1:0]               rd_data;
		logic [NUM_REGS*DW-1:0]      periph_cap;
		// peripheral edges seen in deep sleep with work still pending
		logic [lers_pkg::CNT_W-1:0]  sleep_edges;
	} lers_top_state_t;

	lers_top_state_t           state_ff;
	lers_top_state_t           nxt_state;
	logic                      lf_edge;
	logic [NUM_REGS-1:0]       wr_stb_vec;
	logic [NUM_REGS*DW-1:0]    core_values;
	logic                      bus_awake;

	////////////////////////////////////////////////////////////////////////////
	// the peripheral clock is sampled as a plain synchronous input; only its rising edge matters
	assign lf_edge   = lf_clk_in & ~state_ff.lf_prev;
	// with the core asleep no bus cycle can start, but the channels keep counting [R5]
	assign bus_awake = ~deep_sleep_state;

	always_comb
	begin
		wr_stb_vec = '0;
		for (int i = 0; i < NUM_REGS; i++)
		begin
			// a rewrite while busy is undefined for software; we simply restart that channel [R4]
			if (wr_en && bus_awake && wr_idx == IDX_W'(i))
			begin
				wr_stb_vec[i] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++)
		begin : gen_chan
			lers_chan #(
				.DW      (DW)
			) u_chan (
				.sys_clk  (sys_clk),
				.rstn     (rstn),
				.wr_stb   (wr_stb_vec[g]),
				.wr_data  (wr_data),
				.lf_edge  (lf_edge),
				.hold     (update_hold_bit),
				.pending  (sync_pending_flags[g]), // [R12]
				.core_val (core_values[g*DW +: DW]),
				.lf_val   (lf_reg_values[g*DW +: DW])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_state          = state_ff;
		nxt_state.lf_prev  = lf_clk_in;
		nxt_state.rd_valid = 1'b0;
		// peripheral-owned values are taken only on a peripheral edge, so the
		// core never sees a word mid-change [R6]
		if (lf_edge)
		begin
			nxt_state.periph_cap = periph_value_in;
		end
		// watch counter only: channels keep their own counts, this one proves that
		// a sleeping core never leaves a transfer stranded [R5]
		if (!deep_sleep_state || sync_pending_flags == '0)
		begin
			nxt_state.sleep_edges = lers_pkg::CNT_RESET;
		end
		else if (lf_edge && !update_hold_bit && state_ff.sleep_edges != lers_pkg::EDGES_TO_LAND)
		begin
			nxt_state.sleep_edges = state_ff.sleep_edges + 2'h1;
		end
		if (rd_en && bus_awake)
		begin
			nxt_state.rd_valid = 1'b1;
			if (PERIPH_OWNED[rd_idx])
			begin
				nxt_state.rd_data = state_ff.periph_cap[rd_idx*DW +: DW]; // [R6]
			end
			else
			begin
				// readback may match before the value has landed; the busy flag is the truth [R7] [R8]
				nxt_state.rd_data = core_values[rd_idx*DW +: DW];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_ff.lf_prev    <= 1'b0;
			state_ff.rd_valid   <= 1'b0;
			state_ff.rd_data    <= DW'(lers_pkg::WORD_RESET);
			state_ff.periph_cap <= '0;
			state_ff.sleep_edges <= lers_pkg::CNT_RESET;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign rd_data  = state_ff.rd_data;
	assign rd_valid = state_ff.rd_valid;

	////////////////////////////////////////////////////////////////////////////
	a_core_read_direct: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
		rd_en && bus_awake && !PERIPH_OWNED[rd_idx]
		|=> rd_valid && rd_data == $past(core_values[rd_idx*DW +: DW]))
		else $error("core-domain read did not return core copy");

	a_periph_read_sync: assert property (@(posedge sys_clk) disable iff (!rstn) // [R6]
		rd_en && bus_awake && PERIPH_OWNED[rd_idx]
		|=> rd_valid && rd_data == $past(state_ff.periph_cap[rd_idx*DW +: DW]))
		else $error("peripheral read did not return captured value");

	a_capture_on_edge: assert property (@(posedge sys_clk) disable iff (!rstn) // [R6]
		!lf_edge |=> $stable(state_ff.periph_cap))
		else $error("peripheral capture moved without a peripheral edge");

	a_flags_own_write: assert property (@(posedge sys_clk) disable iff (!rstn) // [R12]
		((sync_pending_flags & ~$past(sync_pending_flags)) & ~$past(wr_stb_vec)) == '0)
		else $error("busy flag rose without a write to its register");

	a_sleep_no_access: assert property (@(posedge sys_clk) disable iff (!rstn) // [R5]
		deep_sleep_state |=> !rd_valid ##0 $past(wr_stb_vec) == '0)
		else $error("bus access taken during deep sleep");

	// three counted edges in deep sleep drain every channel, whatever it had counted before
	a_sleep_lands: assert property (@(posedge sys_clk) disable iff (!rstn) // [R5]
		state_ff.sleep_edges == lers_pkg::EDGES_TO_LAND |-> sync_pending_flags == '0)
		else $error("pending transfer did not finish in deep sleep");

	a_hold_batch: assert property (@(posedge sys_clk) disable iff (!rstn) // [R10]
		update_hold_bit && wr_en && bus_awake
		|=> sync_pending_flags[$past(wr_idx)] && $stable(lf_reg_values))
		else $error("write under hold not kept pending");

	a_hold_freeze_all: assert property (@(posedge sys_clk) disable iff (!rstn) // [R9]
		update_hold_bit[*2] |-> $stable(lf_reg_values))
		else $error("peripheral values changed while hold set");

	a_release_moves: assert property (@(posedge sys_clk) disable iff (!rstn) // [R11]
		$fell(update_hold_bit) && sync_pending_flags != '0 && !$past(wr_en)
		|-> sync_pending_flags == $past(sync_pending_flags))
		else $error("pending flags lost at hold release");

	a_write_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn) // [R3]
		wr_en && bus_awake |=> sync_pending_flags[$past(wr_idx)])
		else $error("accepted write did not raise its busy flag");

	a_hold_keeps_flags: assert property (@(posedge sys_clk) disable iff (!rstn) // [R9]
		update_hold_bit |=> (~sync_pending_flags & $past(sync_pending_flags)) == '0)
		else $error("busy flag cleared while hold was set");

	a_lf_needs_flag: assert property (@(posedge sys_clk) disable iff (!rstn) // [R1]
		$changed(lf_reg_values) |-> $past(sync_pending_flags) != '0)
		else $error("peripheral copy changed with no transfer pending");

	a_cap_follows_edge: assert property (@(posedge sys_clk) disable iff (!rstn) // [R6]
		lf_edge |=> state_ff.periph_cap == $past(periph_value_in))
		else $error("peripheral value not captured on its edge");

	a_read_when_asked: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
		rd_valid |-> $past(rd_en) && !$past(deep_sleep_state))
		else $error("read answer without an accepted request");

	a_read_one_pulse: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
		!(rd_en && bus_awake) |=> !rd_valid)
		else $error("read valid stood longer than one cycle");

	a_rd_data_holds: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
		!(rd_en && bus_awake) |=> $stable(rd_data))
		else $error("read data moved without a read");

endmodule
